// file: hw/gpp_sense.sv
// Per-pin edge/level sensing, sticky flags and group interrupt request
`default_nettype none
module gpp_sense #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Sensing
    input wire logic [WIDTH-1:0] level,
    input wire logic [3*WIDTH-1:0] sense,
    input wire logic [WIDTH-1:0] clear,
    // Results
    output var logic [WIDTH-1:0] flags,
    output var logic irq
);
    logic [WIDTH-1:0] prev;
    logic [WIDTH-1:0] hit;
    logic [WIDTH-1:0] irq_en;
    logic [WIDTH-1:0] next_flags;

    for (genvar i = 0; i < WIDTH; i++) begin : gen_bit
        wire logic [2:0] code = sense[3*i +: 3];
        wire logic rise = level[i] & ~prev[i];
        wire logic fall = ~level[i] & prev[i];
        assign hit[i] = (code == gpp_pkg::SENSE_BOTH) ? (rise | fall) :
                        (code == gpp_pkg::SENSE_RISE) ? rise :
                        (code == gpp_pkg::SENSE_FALL) ? fall :
                        (code == gpp_pkg::SENSE_LOW) ? ~level[i] : 1'b0;
        assign irq_en[i] = (code != gpp_pkg::SENSE_INTDIS) &&
                           (code != gpp_pkg::SENSE_INOFF);
    end

    // Set beats clear in the same cycle
    assign next_flags = (flags & ~clear) | hit;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev <= '0;
            flags <= '0;
            irq <= 1'b0;
        end else if (ce) begin
            prev <= level;
            flags <= next_flags;
            irq <= |(next_flags & irq_en);
        end
    end
endmodule : gpp_sense
`default_nettype wire

// file: hw/gpp_sync.sv
// Two-stage input synchroniser with a per-bit clock enable
`default_nettype none
module gpp_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Data
    input wire logic [WIDTH-1:0] en,
    input wire logic [WIDTH-1:0] d,
    output var logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    // Stages of a disabled input hold, saving power when the input is off
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta <= '0;
            q <= '0;
        end else if (ce) begin
            meta <= (en & d) | (~en & meta);
            q <= (en & meta) | (~en & q);
        end
    end
endmodule : gpp_sync
`default_nettype wire

// file: hw/gpp_top.sv
// Two-group general purpose pin port with AXI4-Lite register access
// What this block does
// - After reset every pad is input: driver off, input buffer on.
// - Two pin groups, each with its own full register set.
// - Bit n of drive-enable and drive-level controls pin n.
// - Config byte for pin n lives at index 0x10 plus n.
// - Drive-enable one drives the pin with its level; zero makes input.
// - Drive-enable set strobe sets only the written-one bits.
// - Drive-enable clear strobe clears only the written-one bits.
// - Drive-enable flip strobe inverts only the written-one bits.
// - Level set strobe forces written-one level bits high.
// - Level clear strobe forces written-one level bits low.
// - Level flip strobe or sampled register write inverts level bits.
// - Sampled register shows synchronised pin level in any direction.
// - Input-off sense setting stops the pin synchroniser clocking.
// - Per-pin sensing: both edges, rising, falling or low level.
// - Asynchronous pin sensing can wake the device without clocks.
// - Every pin is an external interrupt source.
// - Fast alias registers behave exactly like the regular ones.
// - Debug mode does not change port behaviour.
// - Polarity flip inverts input and output; toggling makes an edge.
// - Weak-high-enable bit turns the pin pull-up on.
// - Event output is pin value when input enabled, else zero.
// - Sensed condition sets flag; request holds until flag cleared.
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`default_nettype none
module gpp_top #(
    parameter int ADDR_W = gpp_pkg::ADDR_W
) (
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // AXI4-Lite write
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output var logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output var logic s_axi_wready,
    output var logic [1:0] s_axi_bresp,
    output var logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output var logic s_axi_arready,
    output var logic [31:0] s_axi_rdata,
    output var logic [1:0] s_axi_rresp,
    output var logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins, group g uses bits g*8 upward
    input wire logic [gpp_pkg::NUM_GROUPS*gpp_pkg::PINS-1:0] pin_in,
    output logic [gpp_pkg::NUM_GROUPS*gpp_pkg::PINS-1:0] pin_out,
    output logic [gpp_pkg::NUM_GROUPS*gpp_pkg::PINS-1:0] pin_oe,
    output logic [gpp_pkg::NUM_GROUPS*gpp_pkg::PINS-1:0] pin_pullup,
    // Events, interrupts and wake
    output logic [gpp_pkg::NUM_GROUPS*gpp_pkg::PINS-1:0] pin_event,
    output logic [gpp_pkg::NUM_GROUPS-1:0] group_irq,
    output logic [gpp_pkg::NUM_GROUPS-1:0] external_wake_request
);
    localparam int PINS = gpp_pkg::PINS;
    localparam int LI_W = gpp_pkg::LI_W;

    ////////////////////////////////////////////////////////////////////////
    // Write channel capture: address and data taken in either order
    logic aw_full;
    logic w_full;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic w_lane0;
    logic next_aw_full;
    logic next_w_full;
    logic next_bvalid;

    wire logic aw_take = s_axi_awvalid & s_axi_awready;
    wire logic w_take = s_axi_wvalid & s_axi_wready;
    wire logic wr_go = aw_full & w_full & ~s_axi_bvalid;

    assign next_aw_full = wr_go ? 1'b0 : (aw_full | aw_take);
    assign next_w_full = wr_go ? 1'b0 : (w_full | w_take);
    assign next_bvalid = wr_go ? 1'b1 :
                         (s_axi_bready ? 1'b0 : s_axi_bvalid);

    // Write decode; alias indices fold onto the regular ones
    wire logic [gpp_pkg::IDX_W-1:0] w_idx = aw_addr_q[gpp_pkg::IDX_W+1:2];
    wire logic w_high_zero = (aw_addr_q[ADDR_W-1:gpp_pkg::IDX_W+2] == '0);
    wire logic w_is_alias = (w_idx[6:3] == gpp_pkg::ALIAS_TAG);
    wire logic w_grp = w_is_alias ? w_idx[2] : w_idx[gpp_pkg::GROUP_BIT];
    wire logic [LI_W-1:0] w_li = w_is_alias ?
        gpp_pkg::gpp_alias_index(w_idx[1:0]) : w_idx[LI_W-1:0];
    wire logic w_ok = w_high_zero &
        (w_is_alias | (~w_idx[6] & gpp_pkg::gpp_index_ok(w_idx[LI_W-1:0])));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= gpp_pkg::RESP_OKAY;
        end else if (ce) begin
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            s_axi_awready <= ~next_aw_full;
            s_axi_wready <= ~next_w_full;
            s_axi_bvalid <= next_bvalid;
            if (wr_go) begin
                s_axi_bresp <= w_ok ? gpp_pkg::RESP_OKAY
                                    : gpp_pkg::RESP_DECERR;
            end
        end
    end

    // Payload holders carry no reset; they are read only when full
    always_ff @(posedge aclk) begin
        if (ce && aw_take) begin
            aw_addr_q <= s_axi_awaddr;
        end
        if (ce && w_take) begin
            w_data_q <= s_axi_wdata;
            w_lane0 <= s_axi_wstrb[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel
    logic next_rvalid;
    wire logic ar_take = s_axi_arvalid & s_axi_arready;
    wire logic [gpp_pkg::IDX_W-1:0] r_idx = s_axi_araddr[gpp_pkg::IDX_W+1:2];
    wire logic r_high_zero = (s_axi_araddr[ADDR_W-1:gpp_pkg::IDX_W+2] == '0);
    wire logic r_is_alias = (r_idx[6:3] == gpp_pkg::ALIAS_TAG);
    wire logic r_grp = r_is_alias ? r_idx[2] : r_idx[gpp_pkg::GROUP_BIT];
    wire logic [LI_W-1:0] r_li = r_is_alias ?
        gpp_pkg::gpp_alias_index(r_idx[1:0]) : r_idx[LI_W-1:0];
    wire logic r_ok = r_high_zero &
        (r_is_alias | (~r_idx[6] & gpp_pkg::gpp_index_ok(r_idx[LI_W-1:0])));
    logic [PINS-1:0] grp_rd [gpp_pkg::NUM_GROUPS];

    assign next_rvalid = ar_take ? 1'b1 :
                         (s_axi_rready ? 1'b0 : s_axi_rvalid);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= gpp_pkg::RESP_OKAY;
        end else if (ce) begin
            s_axi_rvalid <= next_rvalid;
            s_axi_arready <= ~next_rvalid;
            if (ar_take) begin
                s_axi_rdata <= r_ok ? {24'h0, grp_rd[r_grp]} : 32'h0;
                s_axi_rresp <= r_ok ? gpp_pkg::RESP_OKAY
                                    : gpp_pkg::RESP_DECERR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin groups; there is no debug input, so debug cannot alter them
    for (genvar g = 0; g < gpp_pkg::NUM_GROUPS; g++) begin : gen_grp
        logic [PINS-1:0] drive_en;
        logic [PINS-1:0] level;
        logic [PINS-1:0][gpp_pkg::CFG_W-1:0] cfg;
        logic [PINS-1:0] pad_level;
        logic [PINS-1:0] event_q;
        logic wake;
        logic [PINS-1:0] next_drive_en;
        logic [PINS-1:0] next_level;
        logic [PINS-1:0] inv_v;
        logic [PINS-1:0] pull_v;
        logic [PINS-1:0] en_v;
        logic [PINS-1:0] both_v;
        logic [PINS-1:0] low_v;
        logic [3*PINS-1:0] sense_v;
        logic [PINS-1:0] sync_q;
        logic [PINS-1:0] flags;
        logic irq;

        wire logic [PINS-1:0] raw = pin_in[g*PINS +: PINS];
        wire logic gw = wr_go & w_ok & w_lane0 &
                        (w_grp == gpp_pkg::GRP_W'(g));
        wire logic [PINS-1:0] d = w_data_q[PINS-1:0];
        // Synchronised level seen through the polarity flip
        wire logic [PINS-1:0] sampled = sync_q ^ inv_v;
        wire logic [PINS-1:0] flag_clear =
            (gw && w_li == gpp_pkg::IDX_FLAGS) ? d : '0;

        for (genvar n = 0; n < PINS; n++) begin : gen_pin
            wire logic [2:0] code =
                cfg[n][gpp_pkg::SENSE_LSB +: gpp_pkg::SENSE_W];
            assign inv_v[n] = cfg[n][gpp_pkg::CFG_FLIP_BIT];
            assign pull_v[n] = cfg[n][gpp_pkg::CFG_PULL_BIT];
            assign sense_v[3*n +: 3] = code;
            assign en_v[n] = (code != gpp_pkg::SENSE_INOFF);
            assign both_v[n] = (code == gpp_pkg::SENSE_BOTH);
            assign low_v[n] = (code == gpp_pkg::SENSE_LOW);
        end

        // Set/clear/flip act only on written-one bits
        assign next_drive_en =
            !gw ? drive_en :
            (w_li == gpp_pkg::IDX_DRIVE_EN) ? d :
            (w_li == gpp_pkg::IDX_DRIVE_EN_SET) ? (drive_en | d) :
            (w_li == gpp_pkg::IDX_DRIVE_EN_CLEAR) ? (drive_en & ~d) :
            (w_li == gpp_pkg::IDX_DRIVE_EN_FLIP) ? (drive_en ^ d) :
            drive_en;
        assign next_level =
            !gw ? level :
            (w_li == gpp_pkg::IDX_LEVEL) ? d :
            (w_li == gpp_pkg::IDX_LEVEL_SET) ? (level | d) :
            (w_li == gpp_pkg::IDX_LEVEL_CLEAR) ? (level & ~d) :
            (w_li == gpp_pkg::IDX_LEVEL_FLIP ||
             w_li == gpp_pkg::IDX_SAMPLED) ? (level ^ d) :
            level;

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                drive_en <= gpp_pkg::DRIVE_EN_RST;
                level <= gpp_pkg::LEVEL_RST;
                cfg <= {PINS{gpp_pkg::CFG_RST}};
                pad_level <= '0;
                event_q <= '0;
            end else if (ce) begin
                drive_en <= next_drive_en;
                level <= next_level;
                if (gw && w_li[4:3] == gpp_pkg::IDX_CFG_BASE[4:3]) begin
                    cfg[w_li[2:0]] <= d;
                end
                pad_level <= level ^ inv_v;
                event_q <= sampled & en_v;
            end
        end

        gpp_sync #(.WIDTH(PINS)) u_sync (
            .aclk(aclk),
            .aresetn(aresetn),
            .ce(ce),
            .en(en_v),
            .d(raw),
            .q(sync_q)
        );

        gpp_sense #(.WIDTH(PINS)) u_sense (
            .aclk(aclk),
            .aresetn(aresetn),
            .ce(ce),
            .level(sampled),
            .sense(sense_v),
            .clear(flag_clear),
            .flags(flags),
            .irq(irq)
        );

        // Asynchronous wake: both-edge and low-level work with clock stopped
        wire logic wake_set =
            |((both_v & ((raw ^ inv_v) ^ sampled)) | (low_v & ~(raw ^ inv_v)));
        always_ff @(posedge aclk or posedge wake_set) begin
            if (wake_set) begin
                wake <= 1'b1;
            end else if (!aresetn) begin
                wake <= 1'b0;
            end else if (ce) begin
                wake <= 1'b0;
            end
        end

        // Strobe locations read back their target register
        assign grp_rd[g] =
            (r_li[4:3] == gpp_pkg::IDX_CFG_BASE[4:3]) ? cfg[r_li[2:0]] :
            (r_li == gpp_pkg::IDX_SAMPLED) ? sampled :
            (r_li == gpp_pkg::IDX_FLAGS) ? flags :
            (r_li <= gpp_pkg::IDX_DRIVE_EN_FLIP) ? drive_en :
            level;

        assign pin_oe[g*PINS +: PINS] = drive_en;
        assign pin_out[g*PINS +: PINS] = pad_level;
        assign pin_pullup[g*PINS +: PINS] = pull_v;
        assign pin_event[g*PINS +: PINS] = event_q;
        assign group_irq[g] = irq;
        assign external_wake_request[g] = wake;
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    wire logic g0_wr = wr_go & w_ok & w_lane0 & ~w_grp & ce;

    chk_dir_set_bits: assert property (
        g0_wr && w_li == gpp_pkg::IDX_DRIVE_EN_SET |=>
        pin_oe[PINS-1:0] == ($past(pin_oe[PINS-1:0]) | $past(w_data_q[7:0])))
        else $error("drive enable set strobe wrong");

    chk_dir_clear_bits: assert property (
        g0_wr && w_li == gpp_pkg::IDX_DRIVE_EN_CLEAR |=>
        pin_oe[PINS-1:0] == ($past(pin_oe[PINS-1:0]) & ~$past(w_data_q[7:0])))
        else $error("drive enable clear strobe wrong");

    chk_dir_flip_bits: assert property (
        g0_wr && w_li == gpp_pkg::IDX_DRIVE_EN_FLIP |=>
        pin_oe[PINS-1:0] == ($past(pin_oe[PINS-1:0]) ^ $past(w_data_q[7:0])))
        else $error("drive enable flip strobe wrong");

    chk_level_set_bits: assert property (
        g0_wr && w_li == gpp_pkg::IDX_LEVEL_SET |=>
        gen_grp[0].level ==
            ($past(gen_grp[0].level) | $past(w_data_q[7:0])))
        else $error("level set strobe wrong");

    chk_sampled_write_flips: assert property (
        g0_wr && w_li == gpp_pkg::IDX_SAMPLED |=>
        gen_grp[0].level ==
            ($past(gen_grp[0].level) ^ $past(w_data_q[7:0])))
        else $error("sampled write did not flip level");

    chk_pad_follows_level: assert property (
        ce |=> pin_out[PINS-1:0] ==
            $past(gen_grp[0].level ^ gen_grp[0].inv_v))
        else $error("pad level not level xor flip");

    chk_event_off_zero: assert property (
        ce && !gen_grp[0].en_v[0] |=> !pin_event[0])
        else $error("event high while input off");

    chk_irq_needs_flag: assert property (
        group_irq[0] |-> gen_grp[0].flags != '0)
        else $error("interrupt without a set flag");

    chk_bresp_holds: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
            $stable(s_axi_bresp))
        else $error("write response dropped early");

    cov_alias_write: cover property (g0_wr && w_is_alias);
    cov_irq_rise: cover property ($rose(group_irq[0]));
    cov_flag_read: cover property (
        ar_take && r_ok && r_li == gpp_pkg::IDX_FLAGS);
    cov_wake: cover property ($rose(external_wake_request[1]));
endmodule : gpp_top
`default_nettype wire

// file: inc/gpp_pkg.sv
// Constants, register map and types shared by the pin port design
`default_nettype none
package gpp_pkg;
    // Structure
    localparam int NUM_GROUPS = 2;
    localparam int PINS = 8;
    localparam int GRP_W = 1;
    localparam int CFG_W = 8;
    localparam int ADDR_W = 12;
    localparam int IDX_W = 7;
    localparam int LI_W = 5;

    ////////////////////////////////////////////////////////////////////////
    // Register indices inside a group; byte address is four times the index
    localparam logic [LI_W-1:0] IDX_DRIVE_EN = 5'h00;
    localparam logic [LI_W-1:0] IDX_DRIVE_EN_SET = 5'h01;
    localparam logic [LI_W-1:0] IDX_DRIVE_EN_CLEAR = 5'h02;
    localparam logic [LI_W-1:0] IDX_DRIVE_EN_FLIP = 5'h03;
    localparam logic [LI_W-1:0] IDX_LEVEL = 5'h04;
    localparam logic [LI_W-1:0] IDX_LEVEL_SET = 5'h05;
    localparam logic [LI_W-1:0] IDX_LEVEL_CLEAR = 5'h06;
    localparam logic [LI_W-1:0] IDX_LEVEL_FLIP = 5'h07;
    localparam logic [LI_W-1:0] IDX_SAMPLED = 5'h08;
    localparam logic [LI_W-1:0] IDX_FLAGS = 5'h09;
    localparam logic [LI_W-1:0] IDX_CFG_BASE = 5'h10;
    // Group g regular block starts at index g * 0x20
    localparam int GROUP_BIT = 5;
    // Fast alias block: index 0x40 + 4*g + {dir, level, sampled, flags}
    localparam logic [3:0] ALIAS_TAG = 4'h8;

    ////////////////////////////////////////////////////////////////////////
    // Per-lead config byte fields and reset values
    localparam int CFG_FLIP_BIT = 7;
    localparam int CFG_PULL_BIT = 3;
    localparam int SENSE_LSB = 0;
    localparam int SENSE_W = 3;
    localparam logic [PINS-1:0] DRIVE_EN_RST = 8'h00;
    localparam logic [PINS-1:0] LEVEL_RST = 8'h00;
    localparam logic [CFG_W-1:0] CFG_RST = 8'h00;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [2:0] {
        SENSE_INTDIS = 3'h0,
        SENSE_BOTH = 3'h1,
        SENSE_RISE = 3'h2,
        SENSE_FALL = 3'h3,
        SENSE_INOFF = 3'h4,
        SENSE_LOW = 3'h5
    } gpp_sense_t;

    function automatic logic [LI_W-1:0] gpp_alias_index(
        input logic [1:0] sel
    );
        case (sel)
            2'h0: gpp_alias_index = IDX_DRIVE_EN;
            2'h1: gpp_alias_index = IDX_LEVEL;
            2'h2: gpp_alias_index = IDX_SAMPLED;
            default: gpp_alias_index = IDX_FLAGS;
        endcase
    endfunction : gpp_alias_index

    function automatic logic gpp_index_ok(input logic [LI_W-1:0] li);
        gpp_index_ok = (li <= IDX_FLAGS) || (li[4:3] == IDX_CFG_BASE[4:3]);
    endfunction : gpp_index_ok
endpackage : gpp_pkg
`default_nettype wire

// file: tb/gpio_pin_port_tb.sv
// Self-checking bench for the pin port
`default_nettype none
module gpio_pin_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] bresp, rresp;
    logic [15:0] pin_in, pin_out, pin_oe, pin_pullup, pin_event;
    logic [15:0] ext_val = 16'h0, ext_drv = 16'hffff;
    logic [1:0] group_irq, wake;
    logic [1:0] bx = 2'h0;
    logic [33:0] expq[$];
    logic [7:0] r, e, lv, x;
    int fails = 0, num_checks = 0;
    always #5 aclk = ~aclk;
    gpp_top u_dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_pullup(pin_pullup), .pin_event(pin_event),
        .group_irq(group_irq), .external_wake_request(wake));
    gpp_pad_model u_pads (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .ext_val(ext_val), .ext_drv(ext_drv),
        .pin_in(pin_in));
    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        if (fails == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_of_test
    task automatic check(input logic [33:0] s, input logic [33:0] x_e);
        num_checks++;
        if (s !== x_e) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, s, x_e);
        end
    endtask : check
    function automatic logic [11:0] ra(input int g, input logic [4:0] i);
        return 12'((g * 32 + int'(i)) * 4);
    endfunction : ra
    task automatic wt(input int n);
        repeat (n) @(negedge aclk);
    endtask : wt
    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic aw, w, b, ta, tw, tb;
        int n;
        aw = 1;
        w = 1;
        b = 1;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (b && n < 60) begin
            @(negedge aclk);
            ta = aw && awready;
            tw = w && wready;
            tb = bvalid;
            @(posedge aclk);
            n++;
            if (ta) begin aw = 0; awvalid <= 0; end
            if (tw) begin w = 0; wvalid <= 0; end
            if (tb) begin b = 0; bready <= 0; end
        end
        if (b) begin fails++; end_of_test(); end
        check(bresp, bx);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [1:0] rs,
            input logic [7:0] d);
        logic ar, rv, ta, tr;
        int n;
        ar = 1;
        rv = 1;
        n = 0;
        expq.push_back({rs, 24'h0, d});
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        while (rv && n < 60) begin
            @(negedge aclk);
            ta = ar && arready;
            tr = rvalid;
            @(posedge aclk);
            n++;
            if (ta) begin ar = 0; arvalid <= 0; end
            if (tr) begin rv = 0; rready <= 0; end
        end
        if (rv) begin fails++; end_of_test(); end
    endtask : rd
    // Read results compared in arrival order
    always @(negedge aclk) begin
        if (rvalid === 1'b1 && rready === 1'b1) begin
            if (expq.size() == 0) check(34'h0, 34'h1);
            else check({rresp, rdata}, expq.pop_front());
        end
    end
    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        end_of_test();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        r = 8'($urandom(32'h12c10f45));
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        wt(1);
        check(pin_oe, 0);
        check(pin_out, 0);
        r = 8'($urandom);
        x = 8'($urandom);
        wr(ra(0, gpp_pkg::IDX_DRIVE_EN_SET), r);
        rd(ra(0, gpp_pkg::IDX_DRIVE_EN), 2'h0, r);
        rd(ra(0, gpp_pkg::IDX_DRIVE_EN_SET), 2'h0, r);
        wr(ra(0, gpp_pkg::IDX_DRIVE_EN_CLEAR), 8'h0f);
        e = r & 8'hf0;
        rd(ra(0, gpp_pkg::IDX_DRIVE_EN), 2'h0, e);
        wr(ra(0, gpp_pkg::IDX_DRIVE_EN_FLIP), 8'h33);
        e = e ^ 8'h33;
        rd(ra(0, gpp_pkg::IDX_DRIVE_EN_FLIP), 2'h0, e);
        check(pin_oe, {8'h0, e});
        wr(ra(0, gpp_pkg::IDX_LEVEL_SET), 8'h81);
        wr(ra(0, gpp_pkg::IDX_LEVEL_CLEAR), 8'h01);
        wr(ra(0, gpp_pkg::IDX_LEVEL_FLIP), 8'h0c);
        wr(ra(0, gpp_pkg::IDX_SAMPLED), 8'h80);
        lv = 8'h0c;
        rd(ra(0, gpp_pkg::IDX_LEVEL), 2'h0, lv);
        check(pin_out[7:0], lv);
        rd(ra(1, gpp_pkg::IDX_DRIVE_EN), 2'h0, 8'h0);
        wr(12'h114, 8'h5a);
        rd(ra(1, gpp_pkg::IDX_LEVEL), 2'h0, 8'h5a);
        @(posedge aclk);
        ext_val <= {8'h0, x};
        wt(5);
        rd(ra(0, gpp_pkg::IDX_SAMPLED), 2'h0, (e & lv) | (~e & x));
        check(pin_event[7:0], (e & lv) | (~e & x));
        wr(ra(0, gpp_pkg::IDX_DRIVE_EN_CLEAR), 8'hff);
        wr(ra(0, gpp_pkg::IDX_CFG_BASE + 5'h2), 8'h04);
        wt(3);
        check(pin_event[2], 1'b0);
        // Input-off pin keeps its last synchronised level
        @(posedge aclk);
        ext_val[2] <= ~x[2];
        wt(4);
        rd(ra(0, gpp_pkg::IDX_SAMPLED), 2'h0, x);
        for (int m = 1; m < 6; m++) begin
            if (m == 4) continue;
            @(posedge aclk);
            ext_val[1] <= 1;
            wr(ra(0, gpp_pkg::IDX_CFG_BASE + 5'h1), 8'(m));
            wt(4);
            wr(ra(0, gpp_pkg::IDX_FLAGS), 8'hff);
            check(group_irq[0], 1'b0);
            @(posedge aclk);
            ext_val[1] <= 0;
            wt(5);
            check(group_irq[0], 1'(m != 2));
            check(wake[0], 1'(m == 5));
            @(posedge aclk);
            ext_val[1] <= 1;
            wt(5);
            rd(ra(0, gpp_pkg::IDX_FLAGS), 2'h0, 8'h02);
            wr(ra(0, gpp_pkg::IDX_FLAGS), 8'h02);
            check(group_irq[0], 1'b0);
        end
        wr(ra(0, gpp_pkg::IDX_CFG_BASE + 5'h3), 8'h08);
        check(pin_pullup[3], 1'b1);
        @(posedge aclk);
        ext_drv[3] <= 0;
        wt(4);
        check(pin_event[3], 1'b1);
        wr(ra(0, gpp_pkg::IDX_DRIVE_EN_SET), 8'h10);
        wr(ra(0, gpp_pkg::IDX_CFG_BASE + 5'h4), 8'h80);
        wt(2);
        check(pin_out[4], 1'b1);
        bx = gpp_pkg::RESP_DECERR;
        wr(ra(1, 5'h1a), 8'hff);
        bx = gpp_pkg::RESP_OKAY;
        rd(ra(0, 5'h0a), gpp_pkg::RESP_DECERR, 8'h0);
        wt(3);
        check(expq.size(), 0);
        end_of_test();
    end
endmodule : gpio_pin_port_tb
`default_nettype wire

// file: tb/gpp_pad_model.sv
// Pads and outside world seen by the pin port
`default_nettype none
module gpp_pad_model (
    // Clock
    input wire logic aclk,
    // Block side
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe,
    input wire logic [15:0] pin_pullup,
    // Outside drivers
    input wire logic [15:0] ext_val,
    input wire logic [15:0] ext_drv,
    output logic [15:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] drift = 16'h0;
    // Floating pad must not hold a stale level
    always_ff @(posedge aclk) drift <= ~drift;
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drv & ext_val)
        | (~pin_oe & ~ext_drv & (pin_pullup | drift));
endmodule : gpp_pad_model
`default_nettype wire
